// [hw/acc_top.v]
// Behaviour
// - Brake enabled and compare one asserts PWM brake
// - Compare brake clears PWM run; software restarts
// - Polarity zero: result>=threshold; one: result<threshold
// - Comparator enable bit turns comparison on/off
// - Compare result read-only, updated per conversion
// - Delay is nine bits, msb in control two
// - External trigger waits programmed delay before start
// - Done flag set on completion, software clears
// - No conversion starts while done flag set
// - Writing start one converts, zero does nothing
// - Start bit reads busy, clears after completion
// - Source field picks PWM_OUT_ZERO, PWM_OUT_TWO, PWM_OUT_FOUR, pin
// - Channel codes 0-7 analog, 8 band-gap
// - Converter off disconnects every analog input
// - Only soft start unless allowed; busy ignores triggers
// - Type field picks fall, rise, centre, end
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "acc_defines.vh"
module acc_top #(
    parameter ADDR_W = 12,
    parameter RES_W = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg conv_start,
    output reg conv_power_on,
    output reg conv_input_connect,
    output reg [3:0] conv_channel,
    input wire conv_done,
    input wire [RES_W-1:0] conv_result_in,
    input wire pwm_out_zero,
    input wire pwm_out_two,
    input wire pwm_out_four,
    input wire external_start_pin,
    input wire pwm_center_point,
    input wire pwm_period_end,
    output reg pwm_fault_brake,
    output reg pwm_run_a,
    output reg irq
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_DELAY = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;

    reg aw_have_reg;
    reg w_have_reg;
    reg [ADDR_W-1:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg [2:0] state_reg;
    reg [8:0] count_reg;
    reg done_reg;
    reg brake_en_reg;
    reg polarity_reg;
    reg cmp_en_reg;
    reg cmp_result_reg;
    reg [8:0] delay_reg;
    reg [1:0] src_reg;
    reg [3:0] chan_reg;
    reg [1:0] type_reg;
    reg ext_allow_reg;
    reg [RES_W-1:0] thresh_reg;
    reg [RES_W-1:0] result_reg;
    reg [3:0] prev_reg;
    reg [`ACC_INT_W-1:0] int_stat_reg;
    reg [`ACC_INT_W-1:0] int_en_reg;
    reg [`ACC_INT_W-1:0] int_stat_next;
    reg cur_sel;
    reg prev_sel;
    reg ext_hit;
    reg cmp_next;
    reg [31:0] rd_word;
    reg rd_ok;
    reg wr_ok;

    wire wr_en = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire [9:0] wr_idx = awaddr_reg[11:2];
    wire [9:0] rd_idx = s_axi_araddr[11:2];
    wire wr_b0 = wr_en & wstrb_reg[0];
    wire wr_b1 = wr_en & wstrb_reg[1];
    wire [3:0] trig_now = {external_start_pin, pwm_out_four, pwm_out_two, pwm_out_zero};
    wire busy = state_reg[2];
    wire start_ok = ~done_reg & ~busy;
    wire soft_go = wr_b0 & (wr_idx == `ACC_IDX_CTRL0) & wdata_reg[`ACC_C0_START];
    wire finish = conv_done & busy;
    wire run_set = wr_b0 & (wr_idx == `ACC_IDX_PWMCTL) & wdata_reg[`ACC_PC_RUN];
    wire brake_evt = finish & brake_en_reg & cmp_next;

    // Trigger source and type selection
    always @* begin
        case (src_reg)
            `ACC_SRC_PWM_OUT_ZERO: begin
                cur_sel = trig_now[0];
                prev_sel = prev_reg[0];
            end
            `ACC_SRC_PWM_OUT_TWO: begin
                cur_sel = trig_now[1];
                prev_sel = prev_reg[1];
            end
            `ACC_SRC_PWM_OUT_FOUR: begin
                cur_sel = trig_now[2];
                prev_sel = prev_reg[2];
            end
            default: begin
                cur_sel = trig_now[3];
                prev_sel = prev_reg[3];
            end
        endcase
        case (type_reg)
            `ACC_TYP_FALL: ext_hit = prev_sel & ~cur_sel;
            `ACC_TYP_RISE: ext_hit = ~prev_sel & cur_sel;
            `ACC_TYP_CENTRE: ext_hit = pwm_center_point;
            default: ext_hit = pwm_period_end;
        endcase
        ext_hit = ext_hit & ext_allow_reg;
    end

    // Comparator on the fresh result
    always @* begin
        if (!cmp_en_reg) begin
            cmp_next = 1'b0;
        end else if (polarity_reg) begin
            cmp_next = (conv_result_in < thresh_reg);
        end else begin
            cmp_next = (conv_result_in >= thresh_reg);
        end
    end

    // Interrupt status, set wins over clear
    always @* begin
        int_stat_next = int_stat_reg;
        if (wr_b0 && wr_idx == `ACC_IDX_INT_CLR) begin
            int_stat_next = int_stat_reg & ~wdata_reg[`ACC_INT_W-1:0];
        end
        int_stat_next[`ACC_INT_DONE] = int_stat_next[`ACC_INT_DONE] | finish;
        int_stat_next[`ACC_INT_CMP] = int_stat_next[`ACC_INT_CMP] | (finish & cmp_next);
        int_stat_next[`ACC_INT_BRAKE] = int_stat_next[`ACC_INT_BRAKE] | brake_evt;
    end

    // Write address decode
    always @* begin
        case (wr_idx)
            `ACC_IDX_CTRL0, `ACC_IDX_CTRL1, `ACC_IDX_CTRL2, `ACC_IDX_DELAY,
            `ACC_IDX_THRESH, `ACC_IDX_PWMCTL, `ACC_IDX_INT_EN,
            `ACC_IDX_INT_CLR: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // Read mux
    always @* begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        case (rd_idx)
            `ACC_IDX_CTRL0: rd_word[7:0] = {done_reg, busy, src_reg, chan_reg};
            `ACC_IDX_CTRL1: rd_word[3:0] = {type_reg, ext_allow_reg, conv_power_on};
            `ACC_IDX_CTRL2: rd_word[7:0] = {brake_en_reg, polarity_reg, cmp_en_reg,
                cmp_result_reg, 3'b000, delay_reg[8]};
            `ACC_IDX_DELAY: rd_word[7:0] = delay_reg[7:0];
            `ACC_IDX_THRESH: rd_word[RES_W-1:0] = thresh_reg;
            `ACC_IDX_RESULT: rd_word[RES_W-1:0] = result_reg;
            `ACC_IDX_PWMCTL: rd_word[1:0] = {pwm_fault_brake, pwm_run_a};
            `ACC_IDX_INT_STAT: rd_word[`ACC_INT_W-1:0] = int_stat_reg;
            `ACC_IDX_INT_EN: rd_word[`ACC_INT_W-1:0] = int_en_reg;
            `ACC_IDX_INT_CLR: rd_word = 32'h00000000;
            default: rd_ok = 1'b0;
        endcase
    end

    // AXI4-Lite channels
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ACC_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `ACC_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Configuration registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            brake_en_reg <= 1'b0;
            polarity_reg <= 1'b0;
            cmp_en_reg <= 1'b0;
            delay_reg <= 9'h000;
            src_reg <= 2'b00;
            chan_reg <= 4'h0;
            type_reg <= 2'b00;
            ext_allow_reg <= 1'b0;
            conv_power_on <= 1'b0;
            thresh_reg <= `ACC_RST_THRESH;
            int_en_reg <= `ACC_RST_INT;
        end else begin
            if (wr_b0 && wr_idx == `ACC_IDX_CTRL2) begin
                brake_en_reg <= wdata_reg[`ACC_C2_BRAKE_EN];
                polarity_reg <= wdata_reg[`ACC_C2_POLARITY];
                cmp_en_reg <= wdata_reg[`ACC_C2_CMP_EN];
                delay_reg[8] <= wdata_reg[`ACC_C2_DELAY_MSB];
            end
            if (wr_b0 && wr_idx == `ACC_IDX_DELAY) begin
                delay_reg[7:0] <= wdata_reg[7:0];
            end
            if (wr_b0 && wr_idx == `ACC_IDX_CTRL0) begin
                src_reg <= wdata_reg[`ACC_C0_SRC_HI:`ACC_C0_SRC_LO];
                chan_reg <= wdata_reg[`ACC_C0_CHAN_HI:0];
            end
            if (wr_b0 && wr_idx == `ACC_IDX_CTRL1) begin
                type_reg <= wdata_reg[`ACC_C1_TYPE_HI:`ACC_C1_TYPE_LO];
                ext_allow_reg <= wdata_reg[`ACC_C1_EXT_ALLOW];
                conv_power_on <= wdata_reg[`ACC_C1_POWER_ON];
            end
            if (wr_b0 && wr_idx == `ACC_IDX_THRESH) begin
                thresh_reg[7:0] <= wdata_reg[7:0];
            end
            if (wr_b1 && wr_idx == `ACC_IDX_THRESH) begin
                thresh_reg[RES_W-1:8] <= wdata_reg[RES_W-1:8];
            end
            if (wr_b0 && wr_idx == `ACC_IDX_INT_EN) begin
                int_en_reg <= wdata_reg[`ACC_INT_W-1:0];
            end
        end
    end

    // Conversion sequencing, delay, done flag and comparator
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            count_reg <= 9'h000;
            conv_start <= 1'b0;
            done_reg <= 1'b0;
            cmp_result_reg <= 1'b0;
            result_reg <= {RES_W{1'b0}};
            prev_reg <= 4'h0;
            conv_channel <= 4'h0;
            conv_input_connect <= 1'b0;
            int_stat_reg <= `ACC_RST_INT;
            irq <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            prev_reg <= trig_now;
            int_stat_reg <= int_stat_next;
            irq <= |(int_stat_reg & int_en_reg);
            conv_channel <= chan_reg;
            conv_input_connect <= conv_power_on & (chan_reg <= `ACC_CHAN_BANDGAP);
            if (wr_b0 && wr_idx == `ACC_IDX_CTRL0 && !wdata_reg[`ACC_C0_DONE]) begin
                done_reg <= 1'b0;
            end
            if (finish) begin
                done_reg <= 1'b1;
                result_reg <= conv_result_in;
                cmp_result_reg <= cmp_next;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (soft_go && start_ok) begin
                        conv_start <= 1'b1;
                        state_reg <= ST_CONV;
                    end else if (ext_hit && start_ok) begin
                        if (delay_reg == 9'h000) begin
                            conv_start <= 1'b1;
                            state_reg <= ST_CONV;
                        end else begin
                            count_reg <= delay_reg;
                            state_reg <= ST_DELAY;
                        end
                    end
                end
                ST_DELAY: begin
                    if ((soft_go && start_ok) || count_reg == 9'h001) begin
                        conv_start <= 1'b1;
                        state_reg <= ST_CONV;
                    end else begin
                        count_reg <= count_reg - 9'h001;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // PWM fault brake and run bit
    always @(posedge aclk) begin
        if (!aresetn) begin
            pwm_fault_brake <= 1'b0;
            pwm_run_a <= 1'b0;
        end else if (brake_evt) begin
            pwm_fault_brake <= 1'b1;
            pwm_run_a <= 1'b0;
        end else if (wr_b0 && wr_idx == `ACC_IDX_PWMCTL) begin
            pwm_run_a <= wdata_reg[`ACC_PC_RUN];
            if (run_set) begin
                pwm_fault_brake <= 1'b0;
            end
        end
    end
endmodule // acc_top

// [hw/acc_defines.vh]
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
// Register indices; byte address is four times the index
`define ACC_IDX_CTRL1 10'h0e1
`define ACC_IDX_CTRL2 10'h0e2
`define ACC_IDX_DELAY 10'h0e3
`define ACC_IDX_CTRL0 10'h0e8
`define ACC_IDX_THRESH 10'h0f0
`define ACC_IDX_RESULT 10'h0f1
`define ACC_IDX_PWMCTL 10'h0f2
`define ACC_IDX_INT_STAT 10'h0f4
`define ACC_IDX_INT_EN 10'h0f5
`define ACC_IDX_INT_CLR 10'h0f6
// Control two fields
`define ACC_C2_BRAKE_EN 7
`define ACC_C2_POLARITY 6
`define ACC_C2_CMP_EN 5
`define ACC_C2_CMP_RESULT 4
`define ACC_C2_DELAY_MSB 0
// Control zero fields
`define ACC_C0_DONE 7
`define ACC_C0_START 6
`define ACC_C0_SRC_HI 5
`define ACC_C0_SRC_LO 4
`define ACC_C0_CHAN_HI 3
// Control one fields
`define ACC_C1_TYPE_HI 3
`define ACC_C1_TYPE_LO 2
`define ACC_C1_EXT_ALLOW 1
`define ACC_C1_POWER_ON 0
// PWM control fields
`define ACC_PC_RUN 0
`define ACC_PC_BRAKE 1
// Interrupt status bits
`define ACC_INT_DONE 0
`define ACC_INT_CMP 1
`define ACC_INT_BRAKE 2
`define ACC_INT_W 3
// Reset values
`define ACC_RST_BYTE 8'h00
`define ACC_RST_THRESH 12'h000
`define ACC_RST_INT 3'h0
// Trigger sources and types
`define ACC_SRC_PWM_OUT_ZERO 2'b00
`define ACC_SRC_PWM_OUT_TWO 2'b01
`define ACC_SRC_PWM_OUT_FOUR 2'b10
`define ACC_SRC_PIN 2'b11
`define ACC_TYP_FALL 2'b00
`define ACC_TYP_RISE 2'b01
`define ACC_TYP_CENTRE 2'b10
`define ACC_TYP_END 2'b11
// Highest analog channel code and band-gap code
`define ACC_CHAN_LAST 4'h7
`define ACC_CHAN_BANDGAP 4'h8
// Bus responses
`define ACC_RESP_OKAY 2'b00
`define ACC_RESP_SLVERR 2'b10
`endif

// [test/acc_checker.sv]
`timescale 1ns/1ps
module acc_checker (
    input wire aclk,
    input wire aresetn,
    input wire conv_start,
    input wire conv_done,
    input wire conv_power_on,
    input wire conv_input_connect,
    input wire [3:0] conv_channel,
    input wire pwm_fault_brake,
    input wire pwm_run_a
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic busy_reg;
    always @(posedge aclk) begin
        if (!aresetn) busy_reg <= 1'b0;
        else if (conv_start) busy_reg <= 1'b1;
        else if (conv_done) busy_reg <= 1'b0;
    end
    sequence s_finish;
        busy_reg && conv_done;
    endsequence
    sequence s_brake_set;
        !pwm_fault_brake ##1 pwm_fault_brake;
    endsequence
    a_start_one_cycle: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_busy_no_start: assert property (busy_reg |-> !conv_start)
        else $error("start while busy");
    a_done_blocks_start: assert property (s_finish |=> !conv_start [*2])
        else $error("start while done set");
    a_off_disconnects: assert property (
        !conv_power_on && !$past(conv_power_on) |-> !conv_input_connect)
        else $error("input connected while off");
    a_reserved_open: assert property (
        conv_channel > 4'h8 && $stable(conv_channel) |-> !conv_input_connect)
        else $error("reserved code connected");
    a_code_connects: assert property (
        conv_channel <= 4'h8 && $stable(conv_channel) && conv_power_on && $past(conv_power_on)
        |-> conv_input_connect) else $error("valid code not connected");
    a_brake_stops_run: assert property (s_brake_set |-> !pwm_run_a)
        else $error("run kept during brake");
    a_brake_from_done: assert property (s_brake_set |-> $past(conv_done))
        else $error("brake without conversion");
    a_brake_release: assert property (pwm_fault_brake ##1 !pwm_fault_brake |-> pwm_run_a)
        else $error("brake left without run");
endmodule // acc_checker
bind acc_top acc_checker i_chk (.aclk, .aresetn, .conv_start, .conv_done, .conv_power_on,
    .conv_input_connect, .conv_channel, .pwm_fault_brake, .pwm_run_a);

// [test/acc_core_model.sv]
`timescale 1ns/1ps
module acc_core_model (
    input wire aclk,
    input wire aresetn,
    input wire conv_start,
    input wire [7:0] latency,
    input wire [11:0] next_result,
    output logic conv_done,
    output logic [11:0] conv_result_in
);
    logic [7:0] cnt_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
            conv_done <= 1'b0;
            conv_result_in <= 12'h000;
        end else begin
            conv_done <= 1'b0;
            conv_result_in <= ~conv_result_in;
            if (conv_start) cnt_reg <= latency;
            else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
                conv_done <= 1'b1;
                conv_result_in <= next_result;
            end
        end
    end
endmodule // acc_core_model

// [test/adc_conversion_control_tb.sv]
`timescale 1ns/1ps
`include "acc_defines.vh"
module adc_conversion_control_tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic conv_start, conv_power_on, conv_input_connect, conv_done, pwm_fault_brake, pwm_run_a;
    logic irq;
    logic [11:0] awaddr, araddr, conv_result_in, next_result;
    logic [31:0] wdata, rdata, seed, v;
    logic [1:0] bresp, rresp, rs, bs;
    logic [3:0] conv_channel;
    logic [5:0] pins;
    logic [7:0] latency;
    int err_count, checked, starts, dones, cyc, t_start;
    acc_top i_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .conv_start,
        .conv_power_on, .conv_input_connect, .conv_channel, .conv_done, .conv_result_in,
        .pwm_out_zero(pins[0]), .pwm_out_two(pins[1]), .pwm_out_four(pins[2]),
        .external_start_pin(pins[3]), .pwm_center_point(pins[4]),
        .pwm_period_end(pins[5]), .pwm_fault_brake, .pwm_run_a, .irq);
    acc_core_model i_core (.aclk, .aresetn, .conv_start, .latency, .next_result, .conv_done,
        .conv_result_in);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1) starts <= starts + 1;
        if (conv_start === 1'b1) t_start <= cyc;
        if (conv_done === 1'b1) dones <= dones + 1;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic exp_cmp(logic en, logic pol, logic [11:0] r, logic [11:0] t);
        return en && (pol ? r < t : r >= t);
    endfunction
    task automatic end_of_test();
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic bound(int n);
        if (n >= 600) begin
            err_count++;
            $display("ERROR wait expected under 600 cycles seen %0d", n);
            end_of_test();
        end
    endtask
    task automatic wr(logic [9:0] idx, logic [31:0] d);
        int n;
        n = 0;
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 600);
        bs = bresp;
        bound(n);
    endtask
    task automatic rdc(string what, logic [9:0] idx, logic [31:0] mask, logic [31:0] exp);
        int n;
        n = 0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 600);
        v = rdata;
        rs = rresp;
        bound(n);
        compare(what, exp, v & mask);
    endtask
    task automatic wait_for(int which, int target);
        int n;
        n = 0;
        while ((which ? dones : starts) < target && n < 600) begin
            @(posedge aclk);
            n++;
        end
        bound(n);
        tick(1);
    endtask
    task automatic pulse(int i);
        pins[i] <= 1'b1;
        tick(1);
        pins[i] <= 1'b0;
        tick(4);
    endtask
    initial begin
        int s, d, lat, base, base0;
        int dl[3] = '{0, 3, 257};
        logic [11:0] r, t;
        logic [2:0] m;
        logic e;
        seed = 32'd93801;
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid} = 3'b000;
        {awaddr, araddr, wdata, pins} = '0;
        next_result = 12'h000;
        latency = 8'h04;
        tick(5);
        aresetn <= 1'b1;
        tick(1);
        rdc("control two", `ACC_IDX_CTRL2, 32'hffffffff, 32'h0);
        rdc("delay", `ACC_IDX_DELAY, 32'hffffffff, 32'h0);
        rdc("control zero", `ACC_IDX_CTRL0, 32'hffffffff, 32'h0);
        rdc("unmapped", 10'h3ff, 32'hffffffff, 32'h0);
        compare("unmapped resp", `ACC_RESP_SLVERR, rs);
        wr(10'h3ff, 32'h0);
        compare("unmapped write resp", `ACC_RESP_SLVERR, bs);
        wr(`ACC_IDX_CTRL1, 32'h1);
        compare("write resp", `ACC_RESP_OKAY, bs);
        for (int c = 0; c < 16; c++) begin
            wr(`ACC_IDX_CTRL0, c);
            tick(2);
            compare("channel", c, conv_channel);
            compare("connect", c <= 8, conv_input_connect);
        end
        wr(`ACC_IDX_CTRL0, 32'h3);
        wr(`ACC_IDX_CTRL1, 32'h0);
        tick(2);
        compare("connect off", 0, conv_input_connect);
        wr(`ACC_IDX_CTRL1, 32'h1);
        wr(`ACC_IDX_PWMCTL, 32'h1);
        for (int i = 0; i < 12; i++) begin
            v = rnd();
            t = v[11:0];
            r = (i == 0) ? t : v[27:16];
            m = (i < 8) ? i[2:0] : v[30:28];
            e = exp_cmp(m[0], m[1], r, t);
            next_result <= r;
            latency <= 8'd8 + v[14:12];
            wr(`ACC_IDX_THRESH, t);
            wr(`ACC_IDX_CTRL2, {m, 5'h0});
            s = dones;
            wr(`ACC_IDX_CTRL0, 32'h40);
            rdc("busy", `ACC_IDX_CTRL0, 32'hc0, 32'h40);
            wait_for(1, s + 1);
            rdc("compare bit", `ACC_IDX_CTRL2, 32'h10, {e, 4'h0});
            rdc("result", `ACC_IDX_RESULT, 32'hfff, r);
            rdc("done idle", `ACC_IDX_CTRL0, 32'hc0, 32'h80);
            rdc("status", `ACC_IDX_INT_STAT, 32'h7, {m[2] & e, e, 1'b1});
            wr(`ACC_IDX_INT_CLR, 32'h7);
            compare("brake", m[2] & e, pwm_fault_brake);
            compare("run", !(m[2] & e), pwm_run_a);
            wr(`ACC_IDX_PWMCTL, 32'h1);
            tick(1);
            compare("run again", 1, pwm_run_a);
            s = starts;
            wr(`ACC_IDX_CTRL0, 32'hc0);
            tick(3);
            compare("start while done", s, starts);
            wr(`ACC_IDX_CTRL0, 32'h0);
            tick(3);
            compare("zero start", s, starts);
            rdc("done cleared", `ACC_IDX_CTRL0, 32'h80, 32'h0);
        end
        wr(`ACC_IDX_INT_EN, 32'h1);
        s = dones;
        wr(`ACC_IDX_CTRL0, 32'h40);
        wait_for(1, s + 1);
        tick(2);
        compare("irq set", 1, irq);
        wr(`ACC_IDX_INT_EN, 32'h0);
        tick(2);
        compare("irq masked", 0, irq);
        wr(`ACC_IDX_INT_EN, 32'h1);
        wr(`ACC_IDX_INT_CLR, 32'h1);
        tick(2);
        compare("irq cleared", 0, irq);
        rdc("status", `ACC_IDX_INT_STAT, 32'h1, 32'h0);
        foreach (dl[k]) begin
            d = dl[k];
            wr(`ACC_IDX_DELAY, d[7:0]);
            wr(`ACC_IDX_CTRL2, d[8]);
            wr(`ACC_IDX_CTRL1, 32'h7);
            wr(`ACC_IDX_CTRL0, 32'h30);
            s = starts;
            pins[3] <= 1'b1;
            base0 = cyc;
            wait_for(0, s + 1);
            lat = t_start - base0;
            if (k == 0) base = lat;
            compare("zero delay", 2, base);
            compare("trigger delay", base + d, lat);
            wait_for(1, dones + 1);
            pins[3] <= 1'b0;
        end
        wr(`ACC_IDX_DELAY, 32'h0);
        wr(`ACC_IDX_CTRL2, 32'h0);
        for (int q = 0; q < 16; q++) begin
            wr(`ACC_IDX_CTRL1, {q[1:0], 2'b11});
            wr(`ACC_IDX_CTRL0, {q[3:2], 4'h0});
            s = starts;
            d = dones;
            pulse((q[3:2] + 1) % 4);
            pulse(q[0] ? 4 : 5);
            compare("stray trigger", s, starts);
            pulse(q[1] ? q[1:0] + 2 : q[3:2]);
            wait_for(1, d + 1);
            compare("trigger", s + 1, starts);
        end
        wr(`ACC_IDX_CTRL1, 32'h5);
        wr(`ACC_IDX_CTRL0, 32'h30);
        s = starts;
        pulse(3);
        compare("trigger not allowed", s, starts);
        latency <= 8'd40;
        wr(`ACC_IDX_CTRL1, 32'h7);
        d = dones;
        pulse(3);
        pulse(3);
        wait_for(1, d + 1);
        compare("busy ignores trigger", s + 1, starts);
        end_of_test();
    end
endmodule // adc_conversion_control_tb
